// [bwac_core.sv]
// Purpose: Acquisition configuration register with balance watchdog and aux settling timer.
// Assumes: Register port is a simple strobed write/read at the documented address.
// Notes: Serial protocol, ADC and alarm logic are outside; only their signals connect here.
// Operation
// - Bits 15, 14, 7, 6 ignore writes and read zero.
// - Prescale code 00 disables the watchdog entirely.
// - Codes 01, 10, 11 give 1 s, 4 s, 16 s steps.
// - Watchdog count decrements once per selected step tick.
// - Count at zero with prescale code 01, 10 or 11 forces every balancing switch off.
// - Broadcast read returns count latched at ninth bit after address.
// - Aux settling time is 5.3 us per count, max 339.2 us.
// - Settling field resets to zero; zero gives one 5.3 us step.
// - Full settling inserted before each enabled aux channel.
// - Thermistor bias output active only during a sequence.
// - Switches forced off by watchdog expiry and overtemperature.
// - Scan request honoured only when no scan runs.
`timescale 1ns/1ps
module bwac_core #(
	parameter int SEC_CYC = bwac_pkg::TICK_1S_CYC,
	parameter int SETTLE_CYC = bwac_pkg::SETTLE_STEP_CYC,
	parameter int NCELL = 12
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Register access.
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// Broadcast read bit timing.
	input wire logic bcast_bit9,
	// Balancing.
	input wire logic [NCELL-1:0] balance_switch_enable,
	input wire logic overtemp,
	output logic [NCELL-1:0] balance_switch_on,
	output logic wdog_expired,
	// Scan sequencing.
	input wire logic scan_req,
	input wire logic scan_done,
	input wire logic aux_input_one_en,
	input wire logic aux_input_two_en,
	input wire logic aux_req,
	output logic aux_settled,
	output logic scan_busy,
	output logic thermistor_bias_output
);
	typedef struct packed {
		logic [15:0] cfg;
		logic [3:0] latched;
		logic [NCELL-1:0] sw;
		logic expired;
		logic busy;
		logic [11:0] sub;
		logic [5:0] steps;
		logic settling;
		logic settled;
		logic bias;
	} bwac_core_type;
	bwac_core_type s_q, s_d;
	function automatic logic [1:0] presc_of(input logic [15:0] w);
		return w[bwac_pkg::PRESC_HI:bwac_pkg::PRESC_LO];
	endfunction
	function automatic logic [3:0] count_of(input logic [15:0] w);
		return w[bwac_pkg::WDOG_HI:bwac_pkg::WDOG_LO];
	endfunction
	function automatic logic [5:0] settle_of(input logic [15:0] w);
		return w[bwac_pkg::SETTLE_HI:bwac_pkg::SETTLE_LO];
	endfunction
	logic step;
	logic cnt_wr;
	assign cnt_wr = reg_wr && reg_addr == bwac_pkg::ACQ_CFG_ADDR;
	bwac_divider #(.SEC_CYC(SEC_CYC)) u_div (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.restart(cnt_wr),
		.presc(presc_of(s_q.cfg)),
		.step(step)
	);
	always_comb begin
		s_d = s_q;
		s_d.settled = 1'b0;
		if (cnt_wr) begin
			s_d.cfg = reg_wdata & bwac_pkg::CFG_WMASK;
		end else if (presc_of(s_q.cfg) != bwac_pkg::PRESC_OFF
				&& step && count_of(s_q.cfg) != 4'h0) begin
			s_d.cfg[bwac_pkg::WDOG_HI:bwac_pkg::WDOG_LO] =
				count_of(s_q.cfg) - 4'h1;
		end
		s_d.expired = presc_of(s_d.cfg) != bwac_pkg::PRESC_OFF
			&& count_of(s_d.cfg) == 4'h0;
		if (s_d.expired || overtemp) begin
			s_d.sw = '0;
		end else begin
			s_d.sw = balance_switch_enable;
		end
		if (bcast_bit9) begin
			s_d.latched = count_of(s_q.cfg);
		end
		if (!s_q.busy && scan_req) begin
			s_d.busy = 1'b1;
		end else if (s_q.busy && scan_done) begin
			s_d.busy = 1'b0;
		end
		s_d.bias = s_d.busy;
		if (!s_q.busy) begin
			s_d.settling = 1'b0;
		end else if (!s_q.settling && aux_req && (aux_input_one_en || aux_input_two_en)) begin
			s_d.settling = 1'b1;
			s_d.sub = '0;
			s_d.steps = settle_of(s_q.cfg);
		end else if (s_q.settling) begin
			if (s_q.sub == 12'(SETTLE_CYC - 1)) begin
				s_d.sub = '0;
				if (s_q.steps == 6'h0) begin
					s_d.settling = 1'b0;
					s_d.settled = 1'b1;
				end else begin
					s_d.steps = s_q.steps - 6'h1;
				end
			end else begin
				s_d.sub = s_q.sub + 12'h1;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.cfg <= bwac_pkg::CFG_RESET;
		end else begin
			s_q <= s_d;
		end
	end
	// Read word shows the latched count in place of the live one.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= {s_q.cfg[15:12], s_d.latched, s_q.cfg[7:0]} & bwac_pkg::CFG_WMASK;
		end
	end
	assign balance_switch_on = s_q.sw;
	assign wdog_expired = s_q.expired;
	assign aux_settled = s_q.settled;
	assign scan_busy = s_q.busy;
	assign thermistor_bias_output = s_q.bias;
endmodule

// [bwac_divider.sv]
// Purpose: Prescale divider giving one-cycle step pulses of 1, 4 or 16 seconds.
// Assumes: Restart clears both stages.
// Notes: Second stage counts 1 s ticks up to the selected multiple.
`timescale 1ns/1ps
module bwac_divider #(
	parameter int SEC_CYC = 40000000
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Control.
	input wire logic restart,
	input wire logic [1:0] presc,
	// Step pulse.
	output logic step
);
	typedef struct packed {
		logic [25:0] cyc;
		logic [3:0] sec;
		logic step;
	} bwac_div_type;
	bwac_div_type s_q, s_d;
	logic [3:0] last_sec;
	always_comb begin
		s_d = s_q;
		s_d.step = 1'b0;
		unique case (presc)
			bwac_pkg::PRESC_1S: last_sec = 4'h0;
			bwac_pkg::PRESC_4S: last_sec = 4'h3;
			default: last_sec = 4'hf;
		endcase
		if (restart || presc == bwac_pkg::PRESC_OFF) begin
			s_d.cyc = '0;
			s_d.sec = '0;
		end else if (s_q.cyc == 26'(SEC_CYC - 1)) begin
			s_d.cyc = '0;
			if (s_q.sec >= last_sec) begin
				s_d.sec = '0;
				s_d.step = 1'b1;
			end else begin
				s_d.sec = s_q.sec + 4'h1;
			end
		end else begin
			s_d.cyc = s_q.cyc + 26'h1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign step = s_q.step;
endmodule

// [bwac_host.sv]
// Purpose: Host model giving the broadcast latch strobe.
// Assumes: Strobe one cycle after the request.
// Notes: Stands for the ninth bit time.
`timescale 1ns/1ps
module bwac_host (
	// Clock.
	input wire logic ref_clk,
	// Read request and latch strobe.
	input wire logic rd_go,
	output logic bcast_bit9
);
	initial bcast_bit9 = 1'b0;
	always @(posedge ref_clk) bcast_bit9 <= rd_go;
endmodule

// [bwac_pkg.sv]
// Purpose: Shared constants for the balance watchdog and acquisition configuration block.
// Assumes: 40 MHz ref_clk, 16-bit register word.
// Notes: Offsets, fields, resets and timing counts live here.
package bwac_pkg;
	localparam logic [7:0] ACQ_CFG_ADDR = 8'h0c;
	localparam int PRESC_HI = 13;
	localparam int PRESC_LO = 12;
	localparam int WDOG_HI = 11;
	localparam int WDOG_LO = 8;
	localparam int SETTLE_HI = 5;
	localparam int SETTLE_LO = 0;
	localparam logic [15:0] CFG_WMASK = 16'h3f3f;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [1:0] PRESC_OFF = 2'h0;
	localparam logic [1:0] PRESC_1S = 2'h1;
	localparam logic [1:0] PRESC_4S = 2'h2;
	localparam logic [1:0] PRESC_16S = 2'h3;
	localparam int CLK_HZ = 40000000;
	localparam int CLK_PS = 25000;
	localparam int SETTLE_STEP_PS = 5300000;
	localparam int SETTLE_STEP_CYC = (SETTLE_STEP_PS + CLK_PS - 1) / CLK_PS;
	localparam int TICK_STEP_S = 1;
	localparam int TICK_1S_CYC = TICK_STEP_S * CLK_HZ;
	localparam int READ_LATCH_BIT = 9;
endpackage

// [bwac_sva.sv]
// Purpose: Port assertions for bwac_core.
// Assumes: Sync active-low nrst.
// Notes: Bound below.
`timescale 1ns/1ps
module bwac_sva #(
	parameter int NCELL = 12
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Balancing.
	input wire logic overtemp,
	input wire logic wdog_expired,
	input wire logic [NCELL-1:0] balance_switch_on,
	// Scan sequencing.
	input wire logic scan_req,
	input wire logic scan_done,
	input wire logic scan_busy,
	input wire logic aux_settled,
	input wire logic thermistor_bias_output,
	// Register read word.
	input wire logic [15:0] reg_rdata
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	chk_rsv_zero: assert property (!reg_rdata[15:14] && !reg_rdata[7:6]) else $error("rsv");
	chk_bias_busy: assert property (thermistor_bias_output == scan_busy) else $error("bias");
	chk_scan_go: assert property (scan_req && !scan_busy |=> scan_busy) else $error("go");
	chk_busy_cause: assert property ($rose(scan_busy) |-> $past(scan_req)) else $error("rise");
	chk_wdog_off: assert property (wdog_expired |-> !balance_switch_on)
		else $error("wdog");
	chk_scan_end: assert property (scan_busy && scan_done |=> !scan_busy) else $error("end");
	chk_heat_off: assert property (overtemp |=> !balance_switch_on) else $error("heat");
	chk_off_idle: assert property (reg_rdata[13:12] == 2'h0 |-> !$past(wdog_expired))
		else $error("idle");
	chk_settle_pulse: assert property (aux_settled |=> !aux_settled) else $error("pulse");
endmodule
bind bwac_core bwac_sva #(.NCELL(NCELL)) u_sva (.*);

// [testbench.sv]
// Purpose: Self-checking bench for bwac_core.
// Assumes: Short counts by parameter.
// Notes: Inputs move 1 ns after a rising edge.
`timescale 1ns/1ps
module testbench;
	localparam int SEC_T = 20;
	localparam int SET_T = 4;
	logic ref_clk = 0, nrst = 0, reg_wr = 0, overtemp = 0, scan_req = 0, scan_done = 0;
	logic aux_req = 0, rd_go = 0, aux_one = 1, aux_two = 0;
	logic bcast_bit9, wdog_expired, aux_settled, scan_busy;
	logic thermistor_bias_output;
	logic [7:0] reg_addr = bwac_pkg::ACQ_CFG_ADDR;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [11:0] bal_en = 12'hfff, balance_switch_on;
	int num_errors = 0, checks_done = 0, n;
	always #12.5 ref_clk = ~ref_clk;
	bwac_host u_host (
		.ref_clk(ref_clk),
		.rd_go(rd_go),
		.bcast_bit9(bcast_bit9)
	);
	bwac_core #(.SEC_CYC(SEC_T), .SETTLE_CYC(SET_T)) u_dut (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.reg_wr(reg_wr),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.bcast_bit9(bcast_bit9),
		.balance_switch_enable(bal_en),
		.overtemp(overtemp),
		.balance_switch_on(balance_switch_on),
		.wdog_expired(wdog_expired),
		.scan_req(scan_req),
		.scan_done(scan_done),
		.aux_input_one_en(aux_one),
		.aux_input_two_en(aux_two),
		.aux_req(aux_req),
		.aux_settled(aux_settled),
		.scan_busy(scan_busy),
		.thermistor_bias_output(thermistor_bias_output)
	);
	task automatic chk(input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
		num_errors += int'(got !== exp);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		#25;
		s = 0;
	endtask
	task automatic wr(input logic [15:0] d);
		reg_wdata = d;
		pulse(reg_wr);
		#50;
	endtask
	function automatic logic watched(input bit pick);
		return pick ? aux_settled : wdog_expired;
	endfunction
	task automatic wait_hi(input bit pick, input int lim);
		for (n = 0; watched(pick) !== 1'b1 && n < lim; n++) #25;
		chk({15'h0000, watched(pick)}, 16'h0001);
		if (watched(pick) !== 1'b1) tally_and_finish();
	endtask
	task automatic tally_and_finish();
		$display("TB: checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic t_reg();
		chk(reg_rdata, 16'h0000);
		wr(16'hffff);
		chk(reg_rdata, 16'h303f);
		pulse(rd_go);
		#75;
		chk(reg_rdata, 16'h3f3f);
		reg_addr = 8'h0d;
		wr(16'h0000);
		reg_addr = bwac_pkg::ACQ_CFG_ADDR;
		chk(reg_rdata, 16'h3f3f);
		$display("t_reg done");
	endtask
	task automatic t_wdog(input logic [1:0] c, input int m);
		wr({2'h0, c, 12'h100});
		#(500 * m - 150);
		chk({3'h0, wdog_expired, balance_switch_on}, 16'h0fff);
		wait_hi(1'b0, 12);
		chk(n[15:0], 16'h0005);
		chk({4'h0, balance_switch_on}, 16'h0000);
		$display("t_wdog done");
	endtask
	task automatic t_scan();
		bal_en = 12'h5a5;
		wr(16'h0002);
		#500;
		chk({3'h0, wdog_expired, balance_switch_on}, 16'h05a5);
		pulse(overtemp);
		chk({4'h0, balance_switch_on}, 16'h0000);
		pulse(scan_req);
		chk({14'h0000, scan_busy, thermistor_bias_output}, 16'h0003);
		pulse(aux_req);
		wait_hi(1'b1, 20);
		chk(n[15:0], 16'((2 + 1) * SET_T));
		aux_one = 0;
		pulse(aux_req);
		n = 0;
		repeat (16) begin
			#25;
			n += int'(aux_settled === 1'b1);
		end
		chk(n[15:0], 16'h0000);
		wr(16'h0000);
		aux_two = 1;
		pulse(aux_req);
		wait_hi(1'b1, 20);
		chk(n[15:0], 16'(SET_T));
		pulse(scan_req);
		pulse(scan_done);
		#25;
		chk({14'h0000, scan_busy, thermistor_bias_output}, 16'h0000);
		$display("t_scan done");
	endtask
	task automatic t_reset();
		wr(16'h3f3f);
		nrst = 0;
		#50;
		chk({2'h0, wdog_expired, scan_busy, balance_switch_on}, 16'h0000);
		chk(reg_rdata, 16'h0000);
		nrst = 1;
		#25;
		chk(reg_rdata, bwac_pkg::CFG_RESET);
		chk({3'h0, wdog_expired, balance_switch_on}, {4'h0, bal_en});
		$display("t_reset done");
	endtask
	initial begin
		#38.5;
		nrst = 1;
		t_reg();
		for (int i = 1; i < 4; i++) t_wdog(i[1:0], 1 << (2 * i - 2));
		t_scan();
		t_reset();
		tally_and_finish();
	end
endmodule
